// ==== core/wdc_cfg.svh ====
// constants for the watchdog clear and period control block
// What this block does
// - Leaving sleep on an RC, timer1 or external clock source clears the watchdog count.
// - Leaving sleep on a crystal or resonator source holds the count cleared until the start-up timer finishes.
// - The 4-bit period field in bits 4 to 1 selects 1:32 at code 0 doubling up to 1:65536 at code 11; codes 12 to 15 are reserved.
// - The enable fuse at 1 keeps the watchdog running whatever the software bit says; with the fuse at 0 the software bit turns it on and off.
// - The time base is the 31 kHz internal oscillator, divided by a 16-bit prescaler by 32 to 65536.
// - While the start-up timer runs the watchdog is held in reset, and counting resumes after it expires.
`ifndef WDC_CFG_SVH
`define WDC_CFG_SVH
`define WDC_REG_CONTROL 4'h0
`define WDC_REG_COUNT 4'h4
`define WDC_REG_STATUS 4'h8
`define WDC_CTRL_RESET 8'h08
`define WDC_CTRL_MASK 8'h1f
`define WDC_EN_BIT 0
`define WDC_PS_LSB 1
`define WDC_PS_MSB 4
`define WDC_PS_MAX 4'hb
`define WDC_PS_BASE 5
`define WDC_LFOSC_HZ 31000
`define WDC_POST_MAX 8'hff
`endif

// ==== core/wdc_none.sv ====
// spare source unit: holds no logic

// ==== core/wdc_pkg.sv ====
// types for the watchdog clear and period control block
package wdc_pkg;
    typedef enum logic [2:0] {
        CLK_TIMER1_OSCILLATOR_CLOCK,
        CLK_EXT_RC,
        CLK_INT_RC,
        CLK_EXT_CLOCK,
        CLK_XTAL,
        CLK_HS_XTAL,
        CLK_LP_XTAL
    } wdc_clk_src_t;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_OST_HOLD
    } wdc_state_t;
endpackage

// ==== core/wdc_watchdog.sv ====
// watchdog clear logic, period prescaler and register slave
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "wdc_cfg.svh"
module wdc_watchdog (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLK_EN_IN,
    input wire logic LFOSC_TICK_IN,
    input wire logic HW_WATCHDOG_ENABLE_FUSE_IN,
    input wire logic CLEAR_WATCHDOG_INSTR_IN,
    input wire logic OSC_FAIL_IN,
    input wire logic SLEEP_EXIT_IN,
    input wire logic [2:0] SYS_CLK_SRC_IN,
    input wire logic OST_DONE_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    output logic WDT_ENABLED_OUT,
    output logic WDT_TIMEOUT_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // register slave: one wait cycle per access, then acknowledge
    logic [7:0] watchdog_control;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] prescale;
    logic [7:0] post;
    wdc_pkg::wdc_state_t state;
    wdc_pkg::wdc_state_t next_state;

    wire req = AVS_READ_IN | AVS_WRITE_IN;
    wire sel_ctrl = AVS_ADDRESS_IN == `WDC_REG_CONTROL;
    wire sel_cnt = AVS_ADDRESS_IN == `WDC_REG_COUNT;
    wire sel_stat = AVS_ADDRESS_IN == `WDC_REG_STATUS;
    wire wr_ctrl = AVS_WRITE_IN & ack & sel_ctrl & AVS_BYTEENABLE_IN[0];
    wire [7:0] next_ctrl = AVS_WRITEDATA_IN[7:0] & `WDC_CTRL_MASK;
    wire [31:0] cnt_word = {8'h00, post, prescale};
    wire [31:0] stat_word = {29'h0, state == wdc_pkg::ST_OST_HOLD, WDT_TIMEOUT_OUT,
                             WDT_ENABLED_OUT};
    wire [31:0] next_rdata = sel_ctrl ? {24'h0, watchdog_control} :
                             sel_cnt ? cnt_word :
                             sel_stat ? stat_word : 32'h0;

    assign AVS_WAITREQUEST_OUT = req & ~ack;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ack <= 1'b0;
            rdata <= 32'h0;
        end else if (CLK_EN_IN) begin
            ack <= req & ~ack;
            if (AVS_READ_IN & ~ack) begin
                rdata <= next_rdata;
            end
        end
    end
    assign AVS_READDATA_OUT = rdata;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            watchdog_control <= `WDC_CTRL_RESET;
        end else if (CLK_EN_IN && wr_ctrl) begin
            watchdog_control <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable and clear decisions
    wire sw_watchdog_enable = watchdog_control[`WDC_EN_BIT];
    wire [3:0] watchdog_period_select = watchdog_control[`WDC_PS_MSB:`WDC_PS_LSB];
    wire wdt_on = HW_WATCHDOG_ENABLE_FUSE_IN | sw_watchdog_enable;
    wire xtal_src = SYS_CLK_SRC_IN == wdc_pkg::CLK_XTAL ||
                    SYS_CLK_SRC_IN == wdc_pkg::CLK_HS_XTAL ||
                    SYS_CLK_SRC_IN == wdc_pkg::CLK_LP_XTAL;
    wire exit_rc = SLEEP_EXIT_IN & ~xtal_src;
    wire exit_xtal = SLEEP_EXIT_IN & xtal_src;
    // software disable with the fuse at 0 stops the count and keeps it cleared
    wire clear_now = CLEAR_WATCHDOG_INSTR_IN | OSC_FAIL_IN | ~wdt_on | exit_rc;
    wire holding = state == wdc_pkg::ST_OST_HOLD;

    always_comb begin
        next_state = state;
        unique case (state)
            wdc_pkg::ST_OFF: if (wdt_on) next_state = wdc_pkg::ST_RUN;
            wdc_pkg::ST_RUN: begin
                if (!wdt_on) next_state = wdc_pkg::ST_OFF;
                else if (exit_xtal) next_state = wdc_pkg::ST_OST_HOLD;
            end
            wdc_pkg::ST_OST_HOLD: begin
                // start-up timer owns the ripple counter until it is done
                if (OST_DONE_IN) next_state = wdt_on ? wdc_pkg::ST_RUN : wdc_pkg::ST_OFF;
            end
            default: next_state = wdc_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            state <= wdc_pkg::ST_OFF;
        end else if (CLK_EN_IN) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler on the low-frequency ticks and 8-bit postscaler
    // reserved period codes clamp to the longest period
    wire [3:0] ps_eff = (watchdog_period_select > `WDC_PS_MAX) ? `WDC_PS_MAX :
                        watchdog_period_select;
    wire [4:0] tap = 5'(ps_eff) + 5'(`WDC_PS_BASE - 1);
    wire [15:0] next_prescale = prescale + 16'h0001;
    // the tap bit falls only when all bits below it roll over together
    wire ps_wrap = LFOSC_TICK_IN & prescale[tap[3:0]] & ~next_prescale[tap[3:0]];
    wire cnt_clear = clear_now | holding | next_state == wdc_pkg::ST_OST_HOLD;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            prescale <= 16'h0000;
            post <= 8'h00;
            WDT_TIMEOUT_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (cnt_clear) begin
                prescale <= 16'h0000;
                post <= 8'h00;
                WDT_TIMEOUT_OUT <= 1'b0;
            end else if (LFOSC_TICK_IN) begin
                prescale <= next_prescale;
                if (ps_wrap) begin
                    post <= post + 8'h01;
                end
                WDT_TIMEOUT_OUT <= ps_wrap && post == `WDC_POST_MAX;
            end else begin
                WDT_TIMEOUT_OUT <= 1'b0;
            end
        end
    end
    assign WDT_ENABLED_OUT = wdt_on;

    ////////////////////////////////////////////////////////////////////////
    // checks

    // enable and clear decisions
    property p_fuse_on;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        HW_WATCHDOG_ENABLE_FUSE_IN |-> WDT_ENABLED_OUT;
    endproperty
    a_fuse_on: assert property (p_fuse_on) else $error("fuse set but disabled");

    property p_en_sw;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        !HW_WATCHDOG_ENABLE_FUSE_IN |-> WDT_ENABLED_OUT == sw_watchdog_enable;
    endproperty
    a_en_sw: assert property (p_en_sw) else $error("software enable ignored");

    property p_off_state;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && state == wdc_pkg::ST_RUN && !wdt_on) |=> state == wdc_pkg::ST_OFF;
    endproperty
    a_off_state: assert property (p_off_state) else $error("watchdog kept running");

    property p_clr;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && (CLEAR_WATCHDOG_INSTR_IN || OSC_FAIL_IN)) |=> prescale == 16'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");

    property p_fail_post;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && OSC_FAIL_IN) |=> post == 8'h0;
    endproperty
    a_fail_post: assert property (p_fail_post) else $error("postscaler kept on fail");

    property p_off;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && !wdt_on) |=> post == 8'h0 && prescale == 16'h0;
    endproperty
    a_off: assert property (p_off) else $error("disabled count moved");

    // sleep exit and start-up hold
    property p_rc_exit;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && exit_rc && state != wdc_pkg::ST_OST_HOLD) |=>
            prescale == 16'h0 && state != wdc_pkg::ST_OST_HOLD;
    endproperty
    a_rc_exit: assert property (p_rc_exit) else $error("rc exit not cleared");

    property p_xtal_exit;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && wdt_on && state == wdc_pkg::ST_RUN && exit_xtal) |=> holding;
    endproperty
    a_xtal_exit: assert property (p_xtal_exit) else $error("no hold on xtal exit");

    property p_hold_stay;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && holding && !OST_DONE_IN) |=> holding;
    endproperty
    a_hold_stay: assert property (p_hold_stay) else $error("hold left too early");

    property p_hold;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        holding |-> prescale == 16'h0 && post == 8'h0;
    endproperty
    a_hold: assert property (p_hold) else $error("count moved during hold");

    property p_resume;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && holding && OST_DONE_IN && wdt_on) |=> state == wdc_pkg::ST_RUN;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after hold");

    // period selection and counting
    property p_ps_range;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        ps_eff <= `WDC_PS_MAX && tap >= 5'd4 && tap <= 5'd15;
    endproperty
    a_ps_range: assert property (p_ps_range) else $error("period tap out of range");

    property p_clamp;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (watchdog_period_select > `WDC_PS_MAX) |-> ps_eff == `WDC_PS_MAX;
    endproperty
    a_clamp: assert property (p_clamp) else $error("reserved code not clamped");

    property p_tick;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && !LFOSC_TICK_IN) |=> $stable(prescale) || prescale == 16'h0;
    endproperty
    a_tick: assert property (p_tick) else $error("prescaler moved without tick");

    property p_wrap_post;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && !cnt_clear && ps_wrap) |=> post == $past(post) + 8'h01;
    endproperty
    a_wrap_post: assert property (p_wrap_post) else $error("postscaler missed a wrap");

    property p_no_wrap_post;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && !cnt_clear && !ps_wrap) |=> $stable(post);
    endproperty
    a_no_wrap_post: assert property (p_no_wrap_post) else $error("postscaler moved alone");

    property p_timeout_cause;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        $rose(WDT_TIMEOUT_OUT) |-> $past(post) == 8'hff && post == 8'h00;
    endproperty
    a_timeout_cause: assert property (p_timeout_cause) else $error("timeout without wrap");

    property p_timeout_pulse;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && WDT_TIMEOUT_OUT) |=> !WDT_TIMEOUT_OUT;
    endproperty
    a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout longer than one");

    // register slave and clock enable
    property p_ctrl_wr;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && wr_ctrl) |=> watchdog_control == $past(next_ctrl);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

    property p_ctrl_upper;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        watchdog_control[7:5] == 3'b000;
    endproperty
    a_ctrl_upper: assert property (p_ctrl_upper) else $error("unused control bits set");

    property p_wr_other;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (AVS_WRITE_IN && !sel_ctrl) |=> $stable(watchdog_control);
    endproperty
    a_wr_other: assert property (p_wr_other) else $error("stray control write");

    property p_wait_first;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (req && !ack) |-> AVS_WAITREQUEST_OUT;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait cycle");

    property p_ack_next;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && req && !ack) |=> ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("access not answered");

    property p_rd_capture;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && AVS_READ_IN && !ack) |=> AVS_READDATA_OUT == $past(next_rdata);
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("read data not taken");

    property p_unmapped;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        (CLK_EN_IN && AVS_READ_IN && !ack && !sel_ctrl && !sel_cnt && !sel_stat) |=>
            AVS_READDATA_OUT == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // a frozen clock enable must leave every counter and register alone
    property p_freeze;
        @(posedge CORE_CLK_IN) disable iff (RST_IN)
        !CLK_EN_IN |=> $stable(prescale) && $stable(post) && $stable(state) &&
            $stable(watchdog_control);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    c_timeout: cover property (@(posedge CORE_CLK_IN) WDT_TIMEOUT_OUT);
    c_hold: cover property (@(posedge CORE_CLK_IN) holding ##1 !holding);
    c_sw_off: cover property (@(posedge CORE_CLK_IN) wdt_on ##1 !wdt_on);
    c_write: cover property (@(posedge CORE_CLK_IN) wr_ctrl);
    c_rc_exit: cover property (@(posedge CORE_CLK_IN) exit_rc && wdt_on);
endmodule

// ==== testbench/watchdog_clear_and_period_ctrl_test.sv ====
// self-checking bench for the watchdog clear and period control block
`timescale 1ns/10ps
module watchdog_clear_and_period_ctrl_test;
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0, fuse = 1'b0, clr = 1'b0, fail = 1'b0;
    logic slp = 1'b0, oscillator_startup_timer = 1'b0, rd_en = 1'b0, wr_en = 1'b0, wreq, en_out;
    logic cen = 1'b1, to_out;
    logic [2:0] src = 3'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, got;
    int failures = 0, compares = 0, cycles = 0;
    always #4 clk = ~clk;
    wdc_watchdog dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(cen),
        .LFOSC_TICK_IN(tick), .HW_WATCHDOG_ENABLE_FUSE_IN(fuse),
        .CLEAR_WATCHDOG_INSTR_IN(clr), .OSC_FAIL_IN(fail), .SLEEP_EXIT_IN(slp),
        .SYS_CLK_SRC_IN(src), .OST_DONE_IN(oscillator_startup_timer), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd_en), .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdat),
        .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
        .WDT_ENABLED_OUT(en_out), .WDT_TIMEOUT_OUT(to_out));
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // request held until the edge where waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        rd_en <= ~w;
        wr_en <= w;
        addr <= a;
        wdat <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        got = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(got, e);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            @(posedge clk);
        end
    endtask
    // one-cycle clear pulse; count must read zero right after
    task automatic wclear();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 30000) begin
            failures++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(4'h0, 32'h08);
        rdchk(4'h8, 32'h0);
        tk(10);
        rdchk(4'h4, 32'h0);
        rdchk(4'hc, 32'h0);
        bus(1'b1, 4'h0, 32'hffffffff);
        rdchk(4'h0, 32'h1f);
        chk({31'h0, en_out}, 32'h1);
        $display("test reset and control done");
        // codes 0 to 3: post ticks after 32<<n periods of the time base
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 4'h0, {27'h0, c[3:0], 1'b1});
            wclear();
            rdchk(4'h4, 32'h0);
            tk((32 << c) + 3);
            rdchk(4'h4, {8'h0, 8'h1, 16'((32 << c) + 3)});
        end
        tk(5);
        fail <= 1'b1;
        @(posedge clk);
        fail <= 1'b0;
        @(posedge clk);
        rdchk(4'h4, 32'h0);
        $display("test period and clears done");
        for (int s = 0; s < 7; s++) begin
            tk(3);
            src <= s[2:0];
            slp <= 1'b1;
            @(posedge clk);
            slp <= 1'b0;
            @(posedge clk);
            if (s >= 4) begin
                tk(4);
                rdchk(4'h4, 32'h0);
                rdchk(4'h8, 32'h5);
                oscillator_startup_timer <= 1'b1;
                @(posedge clk);
                oscillator_startup_timer <= 1'b0;
                @(posedge clk);
            end
            else rdchk(4'h4, 32'h0);
            tk(2);
            rdchk(4'h4, 32'h2);
        end
        $display("test sleep exit done");
        bus(1'b1, 4'h0, 32'h0);
        chk({31'h0, en_out}, 32'h0);
        fuse <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk({31'h0, en_out}, 32'h1);
        tk(3);
        rdchk(4'h4, 32'h3);
        // ticks while frozen must not count
        cen <= 1'b0;
        tk(3);
        cen <= 1'b1;
        rdchk(4'h4, 32'h3);
        fuse <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        rdchk(4'h4, 32'h0);
        $display("test enable fuse done");
        // code 0: timeout after 256 wraps of 32 ticks
        bus(1'b1, 4'h0, 32'h1);
        wclear();
        tick <= 1'b1;
        repeat (8191) @(posedge clk);
        chk({31'h0, to_out}, 32'h0);
        @(posedge clk);
        tick <= 1'b0;
        @(posedge clk);
        chk({31'h0, to_out}, 32'h1);
        @(posedge clk);
        chk({31'h0, to_out}, 32'h0);
        $display("test timeout done");
        conclude();
    end
endmodule
